// file: design/pllcc_top.sv
`timescale 1ns/1ps
// ==========================================================
// pll core clock control top

module pllcc_top
    import pllcc_pkg::*;
(
    input wire logic CLOCK,
    input wire logic SYS_RST,
    input wire logic CE,
    input wire logic PLL_TICK,
    input wire logic PLL_TRACKING,
    input wire logic POWER_DOWN,
    input wire logic IRQ_ACTIVE,
    input wire logic [7:0] SFR_ADDR,
    input wire logic SFR_WR,
    input wire logic SFR_RD,
    input wire logic [7:0] SFR_WDATA,
    output logic [7:0] SFR_RDATA,
    output logic CORE_TICK,
    output logic MOD_TICK,
    output logic TIC_TICK,
    output logic OSC_ENABLE,
    output logic [2:0] CORE_DIV
);

    // ==========================================================
    // declarations
    // carrier to the divider
    pllcc_div_if dif ();

    // stored control image
    logic [7:0] ctrl_q;
    logic [7:0] ctrl_d;
    // lock status and its capture sequencer
    logic lock_q;
    logic lock_d;
    pllcc_lock_e lk_state_q;
    pllcc_lock_e lk_state_d;
    // read data and oscillator side flops
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic osc_en_q;
    logic tic_tick_q;
    logic osc_en_d;
    logic tic_d;

    // decode and selection wires
    logic reg_hit;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_view;
    logic osc_sleep_halt_sel_sel;
    logic fast_irq_response_sel;
    logic [PLLCC_CD_W-1:0] cd_field;
    logic [PLLCC_CD_W-1:0] cd_eff;
    logic osc_run;
    logic irq_fast;
    logic [7:0] wr_new;
    logic [7:0] wr_keep;

    // ==========================================================
    // register access decode
    // address compare against the single mapped register
    // strobes take effect only on edges with the clock enable high
    assign reg_hit = (SFR_ADDR == PLLCC_REG_ADDR);
    assign reg_wr = SFR_WR && reg_hit;
    assign reg_rd = SFR_RD && reg_hit;

    // ==========================================================
    // control fields
    assign osc_sleep_halt_sel_sel = ctrl_q[PLLCC_OSC_SLEEP_HALT_SEL_BIT];
    assign fast_irq_response_sel = ctrl_q[PLLCC_FAST_IRQ_RESPONSE_BIT];
    assign cd_field = ctrl_q[PLLCC_CD_LSB +: PLLCC_CD_W];

    // register image seen by software, lock from its own flop
    // bits 5 and 4 have no function here and are kept as written
    assign reg_view = {ctrl_q[7], lock_q, ctrl_q[5:0]};

    // ==========================================================
    // write path
    // written bits taken only where the mask allows
    assign wr_new = SFR_WDATA & PLLCC_REG_WMASK;
    // masked bits keep their stored value
    assign wr_keep = ctrl_q & ~PLLCC_REG_WMASK;
    assign ctrl_d = reg_wr ? (wr_new | wr_keep) : ctrl_q;

    // the lock bit is held apart from this image
    // control register storage, reset image sets divider to 8
    // power-on value
    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            ctrl_q <= PLLCC_REG_RESET & PLLCC_REG_WMASK;
        end else if (CE) begin
            ctrl_q <= ctrl_d;
        end
    end

    // ==========================================================
    // lock status capture after power-on release
    // one enabled edge in wait, then done until the next reset,
    // so the bit never follows the tracking input later on
    // set when tracking
    always_comb begin
        lk_state_d = lk_state_q;
        lock_d = lock_q;
        case (lk_state_q)
            PLLCC_LK_WAIT: begin
                lock_d = PLL_TRACKING;
                lk_state_d = PLLCC_LK_DONE;
            end
            PLLCC_LK_DONE: begin
                lock_d = lock_q;
            end
            default: begin
                lk_state_d = PLLCC_LK_WAIT;
            end
        endcase
    end

    // lock flop, untouched by writes
    // reset value of one makes the image read 53 during reset
    // read-only status
    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            lock_q <= PLLCC_REG_RESET[PLLCC_LOCK_BIT];
            lk_state_q <= PLLCC_LK_WAIT;
        end else if (CE) begin
            lock_q <= lock_d;
            lk_state_q <= lk_state_d;
        end
    end

    // ==========================================================
    // read path, unaddressed reads return zero
    // read data stands one cycle, then drops back to zero
    // image taken before a same-cycle write lands
    assign rdata_d = reg_rd ? reg_view : 8'h00;

    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            rdata_q <= 8'h00;
        end else if (CE) begin
            rdata_q <= rdata_d;
        end
    end

    // ==========================================================
    // effective core divider
    // the divider applies a new value only at its next period end,
    // so an interrupt may start one slow period before speeding up
    // fastest clock in interrupts
    assign irq_fast = fast_irq_response_sel && IRQ_ACTIVE;
    assign cd_eff = irq_fast ? PLLCC_CD_FASTEST : cd_field;

    // ==========================================================
    // oscillator power-down handling
    // halt when selected
    assign osc_run = !(POWER_DOWN && osc_sleep_halt_sel_sel);
    // halted oscillator also cuts the pll tick feed below,
    // so every tick output stays quiet until it runs again
    assign osc_en_d = osc_run;

    // interval counter tick follows each modulator tick while running
    assign tic_d = dif.mod_tick && osc_run;

    // oscillator enable and interval counter tick
    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            osc_en_q <= 1'b1;
            tic_tick_q <= 1'b0;
        end else if (CE) begin
            osc_en_q <= osc_en_d;
            tic_tick_q <= tic_d;
        end
    end

    // ==========================================================
    // divider hookup, pll tick is crystal times 512
    // clock enable passed down so the divider freezes with the rest
    // div_sel carries the effective exponent, forced or from the field
    // pll clock feed
    assign dif.ce = CE;
    assign dif.pll_tick = PLL_TICK && osc_run;
    assign dif.div_sel = cd_eff;

    pllcc_divider u_div (
        .clk (CLOCK),
        .rst (SYS_RST),
        .dif (dif.div)
    );

    // ==========================================================
    // outputs
    // each output comes from a flop, here or in the divider
    assign SFR_RDATA = rdata_q;
    assign CORE_TICK = dif.core_tick;
    assign MOD_TICK = dif.mod_tick;
    assign TIC_TICK = tic_tick_q;
    assign OSC_ENABLE = osc_en_q;
    assign CORE_DIV = dif.div_applied;

endmodule // pllcc_top

// file: design/pllcc_pkg.sv
// ==========================================================
// pll core clock control constants
package pllcc_pkg;

    // ==========================================================
    // register bus
    localparam logic [7:0] PLLCC_REG_ADDR = 8'hd7;
    localparam logic [7:0] PLLCC_REG_RESET = 8'h53;
    localparam logic [7:0] PLLCC_REG_WMASK = 8'hbf;

    // ==========================================================
    // field positions
    localparam int PLLCC_OSC_SLEEP_HALT_SEL_BIT = 7;
    localparam int PLLCC_LOCK_BIT = 6;
    localparam int PLLCC_FAST_IRQ_RESPONSE_BIT = 3;
    localparam int PLLCC_CD_LSB = 0;
    localparam int PLLCC_CD_W = 3;

    // ==========================================================
    // division ratios
    localparam int PLLCC_PLL_MULT = 512;
    localparam int PLLCC_MOD_CNT_W = 9;
    localparam int PLLCC_CORE_CNT_W = 7;
    localparam logic [PLLCC_MOD_CNT_W-1:0] PLLCC_MOD_LAST = 9'h1ff;
    localparam logic [PLLCC_CORE_CNT_W-1:0] PLLCC_CORE_CNT_RESET = 7'h00;
    localparam logic [PLLCC_CD_W-1:0] PLLCC_CD_FASTEST = 3'h0;

    // ==========================================================
    // lock capture sequencing
    typedef enum logic [1:0] {
        PLLCC_LK_WAIT = 2'b00,
        PLLCC_LK_DONE = 2'b01
    } pllcc_lock_e;

endpackage

// file: design/pllcc_div_if.sv
`timescale 1ns/1ps
// ==========================================================
// link between control logic and clock divider
interface pllcc_div_if;
    import pllcc_pkg::*;
    logic ce;
    logic pll_tick;
    logic [PLLCC_CD_W-1:0] div_sel;
    logic core_tick;
    logic mod_tick;
    logic [PLLCC_CD_W-1:0] div_applied;

    modport ctl (output ce, output pll_tick, output div_sel,
                 input core_tick, input mod_tick, input div_applied);
    modport div (input ce, input pll_tick, input div_sel,
                 output core_tick, output mod_tick, output div_applied);
endinterface

// file: design/pllcc_divider.sv
`timescale 1ns/1ps
// ==========================================================
// core and modulator tick generator
module pllcc_divider
    import pllcc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    pllcc_div_if.div dif
);

    logic [PLLCC_MOD_CNT_W-1:0] mod_cnt_q;
    logic [PLLCC_CORE_CNT_W-1:0] core_cnt_q;
    logic [PLLCC_CD_W-1:0] applied_q;
    logic core_tick_q;
    logic mod_tick_q;
    logic core_wrap;
    logic mod_wrap;
    logic [PLLCC_CORE_CNT_W-1:0] core_reload;

    // ==========================================================
    // wrap decode
    assign mod_wrap = dif.pll_tick && (mod_cnt_q == PLLCC_MOD_LAST);
    assign core_wrap = dif.pll_tick && (core_cnt_q == PLLCC_CORE_CNT_RESET);
    assign core_reload = PLLCC_CORE_CNT_W'((8'h01 << dif.div_sel) - 8'h01);

    // modulator tick every 512 pll clocks, i.e. at crystal rate
    // modulator at crystal rate
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mod_cnt_q <= '0;
            mod_tick_q <= 1'b0;
        end else if (dif.ce) begin
            mod_cnt_q <= dif.pll_tick ? mod_cnt_q + PLLCC_MOD_CNT_W'(1) : mod_cnt_q;
            mod_tick_q <= mod_wrap;
        end
    end

    // core period counter, new ratio only taken at period end
    // whole periods only
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            core_cnt_q <= PLLCC_CORE_CNT_RESET;
            applied_q <= PLLCC_REG_RESET[PLLCC_CD_W-1:0];
            core_tick_q <= 1'b0;
        end else if (dif.ce) begin
            core_tick_q <= core_wrap;
            if (core_wrap) begin
                core_cnt_q <= core_reload;
                applied_q <= dif.div_sel;
            end else if (dif.pll_tick) begin
                core_cnt_q <= core_cnt_q - PLLCC_CORE_CNT_W'(1);
            end
        end
    end

    assign dif.core_tick = core_tick_q;
    assign dif.mod_tick = mod_tick_q;
    assign dif.div_applied = applied_q;

endmodule // pllcc_divider

// file: sim/pllcc_xtal_model.sv
`timescale 1ns/1ps
// =====
// crystal and pll tick source
module pllcc_xtal_model (
    input wire logic clk,
    input wire logic run,
    input wire logic [3:0] gap,
    output logic tick
);
    logic [3:0] cnt_q = 4'h0;
    logic tick_q = 1'b0;
    always @(negedge clk) begin
        cnt_q <= (cnt_q + 4'h1 >= gap) ? 4'h0 : cnt_q + 4'h1;
        tick_q <= run && (cnt_q == 4'h0); // halted oscillator gives no ticks
    end
    assign tick = tick_q;
endmodule // pllcc_xtal_model

// file: sim/pllcc_top_asserts.sv
`timescale 1ns/1ps
// =====
// port checks
module pllcc_top_asserts
    import pllcc_pkg::*;
(
    input wire logic CLOCK,
    input wire logic SYS_RST,
    input wire logic CE,
    input wire logic PLL_TICK,
    input wire logic POWER_DOWN,
    input wire logic SFR_WR,
    input wire logic SFR_RD,
    input wire logic [7:0] SFR_ADDR,
    input wire logic [7:0] SFR_WDATA,
    input wire logic [7:0] SFR_RDATA,
    input wire logic CORE_TICK,
    input wire logic MOD_TICK,
    input wire logic TIC_TICK,
    input wire logic OSC_ENABLE,
    input wire logic [2:0] CORE_DIV
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (SYS_RST);
    // =====
    // register access
    sequence wr_hit; CE && SFR_WR && SFR_ADDR == PLLCC_REG_ADDR; endsequence
    sequence rd_hit; CE && SFR_RD && !SFR_WR && SFR_ADDR == PLLCC_REG_ADDR; endsequence
    rd_miss_a: assert property (CE && SFR_RD && SFR_ADDR != PLLCC_REG_ADDR |=>
        SFR_RDATA == 8'h00)
        else $error("unmapped read not zero");
    wr_rd_a: assert property (wr_hit ##1 rd_hit |=>
        (SFR_RDATA & PLLCC_REG_WMASK) == ($past(SFR_WDATA, 2) & PLLCC_REG_WMASK))
        else $error("written fields not read back");
    // =====
    // tick, oscillator enable and divider outputs
    core_cause_a: assert property (CORE_TICK && $past(CE) |-> $past(PLL_TICK))
        else $error("core tick without pll tick");
    mod_cause_a: assert property (MOD_TICK && $past(CE) |-> $past(PLL_TICK))
        else $error("mod tick without pll tick");
    mod_pulse_a: assert property (MOD_TICK && CE |=> !MOD_TICK)
        else $error("mod tick too long");
    tic_gate_a: assert property (TIC_TICK && $past(CE) |-> $past(MOD_TICK))
        else $error("tic tick without mod tick");
    osc_run_a: assert property (CE && !POWER_DOWN |=> OSC_ENABLE)
        else $error("oscillator stopped while awake");
    div_edge_a: assert property ($changed(CORE_DIV) |-> CORE_TICK)
        else $error("divider changed mid period");
endmodule // pllcc_top_asserts

// file: sim/tb.sv
`timescale 1ns/1ps
// =====
// clock control bench
module tb;
    typedef struct {logic [7:0] w; logic [7:0] r; int p;} pllcc_row_s;
    logic clk = 1'b0, rst = 1'b1, pd = 1'b0, irq = 1'b0, trk = 1'b1, wr = 1'b0, rd = 1'b0;
    logic ce = 1'b1;
    logic [7:0] addr = 8'hd7, wdata = 8'h00, rdata;
    logic [3:0] gap = 4'h2;
    logic pll_tick, core_tick, mod_tick, tic_tick, osc_en;
    logic [2:0] core_div;
    int fail_count = 0, n_compared = 0, cyc = 0, c;
    pllcc_row_s rows [8] = '{'{8'h00, 8'h40, 2}, '{8'h81, 8'hc1, 4}, '{8'h62, 8'h62, 8},
        '{8'hb3, 8'hf3, 16}, '{8'h14, 8'h54, 32}, '{8'ha5, 8'he5, 64}, '{8'h26, 8'h66, 128},
        '{8'h37, 8'h77, 256}};
    always #2.5 clk = ~clk;
    pllcc_xtal_model u_pllcc_xtal_model (.clk(clk), .run(osc_en), .gap(gap), .tick(pll_tick));
    pllcc_top u_pllcc_top (.CLOCK(clk), .SYS_RST(rst), .CE(ce), .PLL_TICK(pll_tick),
        .PLL_TRACKING(trk), .POWER_DOWN(pd), .IRQ_ACTIVE(irq), .SFR_ADDR(addr), .SFR_WR(wr),
        .SFR_RD(rd), .SFR_WDATA(wdata), .SFR_RDATA(rdata), .CORE_TICK(core_tick),
        .MOD_TICK(mod_tick), .TIC_TICK(tic_tick), .OSC_ENABLE(osc_en), .CORE_DIV(core_div));
    // =====
    // compare and bus tasks
    task automatic bad(input logic [31:0] g, input logic [31:0] e);
        fail_count++;
        $display("Error t=%0t got=%h exp=%h", $time, g, e);
    endtask
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        n_compared++;
        if (g !== e) bad(g, e);
    endtask
    task automatic chkn(input int g, input int e);
        n_compared++;
        if (g != e) bad(g, e);
    endtask
    task automatic wr8(input logic [7:0] d);
        addr = 8'hd7;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask
    task automatic rd8(input logic [7:0] a, input logic [7:0] e);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        chk8(rdata, e);
    endtask
    // cycles between two pulses: 0 core, 1 mod, 2 tic
    task automatic gap_of(input int m, output int n);
        repeat (2) begin
            n = 0;
            do begin
                @(negedge clk);
                n++;
            end while ((m == 2 ? tic_tick : m ? mod_tick : core_tick) !== 1'b1 && n < 3000);
        end
    endtask
    task automatic wdiv(input logic [2:0] d);
        repeat (600) if (core_div !== d) @(negedge clk);
        chk8({5'h0, core_div}, {5'h0, d});
    endtask
    task automatic print_verdict;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // cycle ceiling
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            fail_count++;
            print_verdict;
        end
    end
    // =====
    // main sequence
    initial begin
        repeat (2) @(negedge clk);
        rst = 1'b0;
        rd8(8'hd7, 8'h53);
        chk8({5'h0, core_div}, 8'h03);
        @(negedge clk);
        rd8(8'hd6, 8'h00);
        foreach (rows[i]) begin
            wr8(rows[i].w);
            rd8(8'hd7, rows[i].r);
            wdiv(rows[i].w[2:0]);
            gap_of(0, c);
            chkn(c, rows[i].p);
        end
        gap_of(1, c);
        chkn(c, 1024);
        irq = 1'b1;
        repeat (600) @(negedge clk);
        chk8({5'h0, core_div}, 8'h07);
        wr8(8'h0f);
        wdiv(3'h0);
        irq = 1'b0;
        wdiv(3'h7);
        wr8(8'h80);
        pd = 1'b1;
        repeat (3) @(negedge clk);
        chk8({7'h0, osc_en}, 8'h00);
        wr8(8'h00);
        repeat (3) @(negedge clk);
        chk8({7'h0, osc_en}, 8'h01);
        gap_of(2, c);
        chkn(c, 1024);
        pd = 1'b0;
        trk = 1'b0;
        rst = 1'b1;
        @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        rd8(8'hd7, 8'h13);
        wr8(8'h40);
        rd8(8'hd7, 8'h00);
        // write with clock enable low must not land
        ce = 1'b0;
        wr8(8'h05);
        ce = 1'b1;
        rd8(8'hd7, 8'h00);
        print_verdict;
    end
endmodule // tb

bind pllcc_top pllcc_top_asserts u_pllcc_top_asserts (.CLOCK(CLOCK), .SYS_RST(SYS_RST),
    .CE(CE), .PLL_TICK(PLL_TICK), .POWER_DOWN(POWER_DOWN), .SFR_WR(SFR_WR), .SFR_RD(SFR_RD),
    .SFR_ADDR(SFR_ADDR), .SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA), .CORE_TICK(CORE_TICK),
    .MOD_TICK(MOD_TICK), .TIC_TICK(TIC_TICK), .OSC_ENABLE(OSC_ENABLE), .CORE_DIV(CORE_DIV));
